// file: logic/seq_consts.svh
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH
// Register byte offsets
`define R_CTRL    8'h00
`define R_STAT    8'h04
`define R_IRQ_ST  8'h08
`define R_IRQ_CLR 8'h0c
`define R_IRQ_EN  8'h10
`define R_HDR_LO  8'h14
`define R_HDR_HI  8'h18
`define R_USER    8'h1c
// Control fields
`define CTRL_RESTART 0
`define CTRL_BAUD_LO 4
`define BAUD_RST     4'h0
`define BAUD_SEL_MAX 4'h9
// Interrupt bit positions
`define IRQ_PRM  0
`define IRQ_CFG  1
`define IRQ_DX   2
`define IRQ_REF  3
`define IRQ_ADDR 4
`define IRQ_W    5
// Station address and message limits
`define ADDR_MAX  7'd125
`define HDR_BYTES 10'd7
`define PRM_MAX   10'd244
`define MSG_MAX   10'd256
// Switch settle delay after reset, in cycles
`define SETTLE    2'd3
// Lamp blink half period
`define CLK_KHZ      50000
`define BLINK_HALF_MS 250
`endif

// file: logic/seq_pkg.sv
package seq_pkg;
  typedef enum logic [2:0] {
    PH_INIT = 3'b000,
    PH_PRM  = 3'b001,
    PH_SRST = 3'b010,
    PH_CFG  = 3'b011,
    PH_DATA = 3'b100
  } phase_t;
  typedef enum logic [1:0] {
    MK_PRM   = 2'b00,
    MK_CFG   = 2'b01,
    MK_OUT   = 2'b10,
    MK_OTHER = 2'b11
  } msg_kind_t;
  typedef struct packed {
    logic      valid;
    logic      first;
    logic      last;
    msg_kind_t kind;
    logic [7:0] data;
  } rx_t;
  typedef struct packed {
    logic       valid;
    logic       last;
    logic       commit;
    logic       discard;
    logic [7:0] data;
  } out_t;
  typedef struct packed {
    logic red;
    logic green;
  } lamp_t;
endpackage

// file: logic/lamp_driver.sv
`timescale 1ns/1ps
`include "seq_consts.svh"
module lamp_driver #(
  parameter int BLINK_CYC = 8
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          dx_active,
  input  wire logic          comm_active,
  input  wire logic          sys_fault,
  input  wire logic          warn_alarm,
  output seq_pkg::lamp_t     bus_fault_lamp,
  output seq_pkg::lamp_t     system_fault_lamp
);
  import seq_pkg::*;

  initial if (BLINK_CYC < 1) $error("BLINK_CYC must be at least 1");

  logic [31:0] blink_cnt_r;
  logic        blink_r;

  // Free running blink phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      blink_cnt_r <= 32'h0;
      blink_r     <= 1'b0;
    end
    else if (blink_cnt_r >= 32'(BLINK_CYC - 1))
    begin
      blink_cnt_r <= 32'h0;
      blink_r     <= ~blink_r;
    end
    else
      blink_cnt_r <= blink_cnt_r + 32'h1;

  // Bus lamp: green in exchange, red when silent, blinking otherwise
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      bus_fault_lamp <= '{red: 1'b1, green: 1'b0};
    else if (dx_active)
      bus_fault_lamp <= '{red: 1'b0, green: 1'b1};
    else if (!comm_active)
      bus_fault_lamp <= '{red: 1'b1, green: 1'b0};
    else
      bus_fault_lamp <= '{red: blink_r, green: 1'b0};

  // System lamp: steady red on failure, blinking on warning
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      system_fault_lamp <= '{red: 1'b0, green: 1'b0};
    else if (sys_fault)
      system_fault_lamp <= '{red: 1'b1, green: 1'b0};
    else if (warn_alarm)
      system_fault_lamp <= '{red: blink_r, green: 1'b0};
    else
      system_fault_lamp <= '{red: 1'b0, green: 1'b0};

  property p_bus_green;
    @(posedge hclk) disable iff (!hresetn)
    dx_active |=> bus_fault_lamp.green && !bus_fault_lamp.red;
  endproperty
  a_bus_green: assert property (p_bus_green) else $error("bus lamp not green in exchange");

  property p_sys_red;
    @(posedge hclk) disable iff (!hresetn)
    sys_fault |=> system_fault_lamp.red && !system_fault_lamp.green;
  endproperty
  a_sys_red: assert property (p_sys_red) else $error("system lamp not red on failure");
endmodule

// file: logic/fieldbus_slave_startup_sequencer.sv
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "seq_consts.svh"
module fieldbus_slave_startup_sequencer #(
  parameter int BLINK_CYC = `BLINK_HALF_MS * `CLK_KHZ
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic [31:0]        hrdata,
  output logic               hresp,
  input  wire logic [3:0]    addr_sw_hi,
  input  wire logic [3:0]    addr_sw_lo,
  input  wire logic          comm_active,
  input  wire seq_pkg::rx_t  rx,
  input  wire logic          sys_fault,
  input  wire logic          warn_alarm,
  output seq_pkg::out_t      out_data,
  output logic [6:0]         station_addr,
  output logic [3:0]         baud_sel,
  output logic               servo_rst,
  output logic               dx_active,
  output logic               irq,
  output seq_pkg::lamp_t     bus_fault_lamp,
  output seq_pkg::lamp_t     system_fault_lamp
);
  import seq_pkg::*;

  initial if (BLINK_CYC < 1) $error("BLINK_CYC must be at least 1");

  phase_t      phase_r;
  logic [7:0]  sw_s1_r, sw_s2_r, sw_s3_r;
  logic [1:0]  settle_r;
  logic        addr_taken_r, addr_ok_r;
  logic        prm_done_r, cfg_done_r;
  msg_kind_t   kind_r;
  msg_kind_t   kind_sel;
  logic [9:0]  cnt_r, cnt_nxt;
  logic [55:0] hdr_r;
  logic [7:0]  user_cnt_r, out_len_r;
  logic [5:0]  irq_st_r, irq_en_r, ev;
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic        restart, len_bad, take_prm, take_cfg, take_out, refuse;

  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    unique case (a)
      `R_CTRL:   rd_mux = {baud_sel, 4'h0};
      `R_STAT:   rd_mux = {dx_active, 1'b0, cfg_done_r, prm_done_r, addr_ok_r, phase_r};
      `R_IRQ_ST: rd_mux = {2'b00, irq_st_r};
      `R_IRQ_EN: rd_mux = {2'b00, irq_en_r};
      `R_USER:   rd_mux = user_cnt_r;
      default:   rd_mux = 8'h00;
    endcase
  endfunction

  // Word-wide read data, header registers and station address above bit 7
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    unique case (a)
      `R_HDR_LO: rd_word = hdr_r[31:0];
      `R_HDR_HI: rd_word = {8'h00, hdr_r[55:32]};
      `R_STAT:   rd_word = {14'h0, sys_fault, warn_alarm, 1'b0, station_addr, rd_mux(a)};
      default:   rd_word = {24'h0, rd_mux(a)};
    endcase
  endfunction

  // Switch pins pass three flops; a change counts once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      sw_s1_r <= 8'h00;
      sw_s2_r <= 8'h00;
      sw_s3_r <= 8'h00;
    end
    else
    begin
      sw_s1_r <= {addr_sw_hi, addr_sw_lo};
      sw_s2_r <= sw_s1_r;
      sw_s3_r <= sw_s2_r;
    end

  // Address caught once after power-up release, range checked
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      settle_r     <= 2'd0;
      addr_taken_r <= 1'b0;
      addr_ok_r    <= 1'b0;
      station_addr <= 7'd0;
    end
    else if (settle_r != `SETTLE)
      settle_r <= settle_r + 2'd1;
    else if (!addr_taken_r && sw_s2_r == sw_s3_r)
    begin
      addr_taken_r <= 1'b1;
      addr_ok_r    <= !sw_s3_r[7] && sw_s3_r[6:0] <= `ADDR_MAX;
      station_addr <= sw_s3_r[6:0];
    end

  // Message framing and acceptance decisions on the last byte
  assign cnt_nxt  = rx.first ? 10'd1 : (cnt_r == 10'h3ff ? cnt_r : cnt_r + 10'd1);
  assign len_bad  = cnt_nxt > `MSG_MAX;
  assign take_prm = rx.valid && rx.last && kind_sel == MK_PRM && phase_r == PH_PRM && !len_bad
                    && cnt_nxt >= `HDR_BYTES && cnt_nxt <= `PRM_MAX;
  assign take_cfg = rx.valid && rx.last && kind_sel == MK_CFG && phase_r == PH_CFG && !len_bad;
  assign take_out = rx.valid && rx.last && kind_sel == MK_OUT && phase_r == PH_DATA && !len_bad
                    && cnt_nxt == {2'b00, out_len_r};
  assign refuse   = rx.valid && rx.last && kind_sel != MK_OTHER && !take_prm && !take_cfg && !take_out;

  // Kind of the message in flight comes with its first byte
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      kind_r <= MK_OTHER;
    else if (rx.valid && rx.first)
      kind_r <= rx.kind;

  always_comb
  begin
    kind_sel = rx.first ? rx.kind : kind_r;
  end

  // Byte count of the current message
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      cnt_r <= 10'd0;
    else if (rx.valid)
      cnt_r <= cnt_nxt;

  // Standard header bytes and user parameter count
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      hdr_r      <= 56'h0;
      user_cnt_r <= 8'h00;
    end
    else if (rx.valid && kind_sel == MK_PRM && phase_r == PH_PRM)
    begin
      if (cnt_nxt <= `HDR_BYTES)
        hdr_r <= {rx.data, hdr_r[55:8]};
      if (take_prm)
        user_cnt_r <= 8'(cnt_nxt - `HDR_BYTES);
    end

  // Configured output length is the first configuration byte
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      out_len_r <= 8'h00;
    else if (rx.valid && rx.first && rx.kind == MK_CFG && phase_r == PH_CFG)
      out_len_r <= rx.data;

  // Phase sequence
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      phase_r    <= PH_INIT;
      prm_done_r <= 1'b0;
      cfg_done_r <= 1'b0;
    end
    else if (restart)
    begin
      phase_r    <= PH_INIT;
      prm_done_r <= 1'b0;
      cfg_done_r <= 1'b0;
    end
    else
      unique case (phase_r)
        PH_INIT:
          if (addr_ok_r && comm_active)
            phase_r <= PH_PRM;
        PH_PRM:
          if (take_prm)
          begin
            phase_r    <= PH_SRST;
            prm_done_r <= 1'b1;
          end
        PH_SRST:
          phase_r <= PH_CFG;
        PH_CFG:
          if (take_cfg)
          begin
            cfg_done_r <= 1'b1;
            phase_r    <= PH_DATA;
          end
        PH_DATA:
          phase_r <= PH_DATA;
        default:
          phase_r <= PH_INIT;
      endcase

  // Servo reset and exchange flag follow the phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      servo_rst <= 1'b0;
      dx_active <= 1'b0;
    end
    else
    begin
      servo_rst <= take_prm;
      dx_active <= phase_r == PH_DATA && !restart;
    end

  // Output bytes forwarded in exchange, committed only when format matches
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      out_data <= '0;
    else
    begin
      out_data.valid   <= rx.valid && kind_sel == MK_OUT && phase_r == PH_DATA;
      out_data.last    <= rx.valid && rx.last;
      out_data.commit  <= take_out;
      out_data.discard <= rx.valid && rx.last && kind_sel == MK_OUT && !take_out;
      out_data.data    <= rx.data;
    end

  // Interrupt events
  always_comb
  begin
    ev            = 6'h00;
    ev[`IRQ_PRM]  = take_prm;
    ev[`IRQ_CFG]  = take_cfg;
    ev[`IRQ_DX]   = take_out;
    ev[`IRQ_REF]  = refuse;
    ev[`IRQ_ADDR] = settle_r == `SETTLE && !addr_taken_r && sw_s2_r == sw_s3_r
                    && (sw_s3_r[7] || sw_s3_r[6:0] > `ADDR_MAX);
  end

  // AHB address phase: accept, latch write, register read data
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= hsel && hready && htrans[1] && hwrite;
      wr_addr_r <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite)
        hrdata <= haddr[31:8] == 24'h0 ? rd_word(haddr[7:0]) : 32'h0;
    end

  assign restart = wr_pend_r && wr_addr_r == `R_CTRL && hwdata[`CTRL_RESTART];

  // Control register: bit rate select, out-of-range values ignored
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      baud_sel <= `BAUD_RST;
    else if (wr_pend_r && wr_addr_r == `R_CTRL && hwdata[`CTRL_BAUD_LO +: 4] <= `BAUD_SEL_MAX)
      baud_sel <= hwdata[`CTRL_BAUD_LO +: 4];

  // Sticky status, set wins over clear; enable register
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      irq_st_r <= 6'h00;
      irq_en_r <= 6'h00;
    end
    else
    begin
      if (wr_pend_r && wr_addr_r == `R_IRQ_CLR)
        irq_st_r <= (irq_st_r & ~hwdata[5:0]) | ev;
      else
        irq_st_r <= irq_st_r | ev;
      if (wr_pend_r && wr_addr_r == `R_IRQ_EN)
        irq_en_r <= hwdata[5:0];
    end

  // Level interrupt
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_st_r & irq_en_r);

  lamp_driver #(
    .BLINK_CYC (BLINK_CYC)
  ) u_lamps (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .dx_active         (dx_active),
    .comm_active       (comm_active),
    .sys_fault         (sys_fault),
    .warn_alarm        (warn_alarm),
    .bus_fault_lamp    (bus_fault_lamp),
    .system_fault_lamp (system_fault_lamp)
  );

  sequence s_prm_accept;
    take_prm;
  endsequence
  sequence s_servo_pulse;
    servo_rst && phase_r == PH_SRST ##1 !servo_rst && phase_r == PH_CFG;
  endsequence

  property p_servo_rst;
    @(posedge hclk) disable iff (!hresetn)
    s_prm_accept |=> s_servo_pulse;
  endproperty
  a_servo_rst: assert property (p_servo_rst) else $error("no servo reset after parameterization");

  property p_addr_range;
    @(posedge hclk) disable iff (!hresetn)
    addr_ok_r |-> station_addr <= `ADDR_MAX;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("station address out of range accepted");

  property p_addr_hold;
    @(posedge hclk) disable iff (!hresetn)
    $past(addr_taken_r) |-> $stable(station_addr) && $stable(addr_ok_r);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("station address changed after capture");

  property p_order;
    @(posedge hclk) disable iff (!hresetn)
    phase_r == PH_PRM && !restart |=> phase_r inside {PH_PRM, PH_SRST};
  endproperty
  a_order: assert property (p_order) else $error("phase skipped");

  property p_dx_gate;
    @(posedge hclk) disable iff (!hresetn)
    dx_active |-> prm_done_r && cfg_done_r;
  endproperty
  a_dx_gate: assert property (p_dx_gate) else $error("exchange without parameters and configuration");

  property p_prm_once;
    @(posedge hclk) disable iff (!hresetn)
    prm_done_r && !restart |-> !take_prm;
  endproperty
  a_prm_once: assert property (p_prm_once) else $error("second parameterization accepted");

  property p_len;
    @(posedge hclk) disable iff (!hresetn)
    rx.valid && rx.last && cnt_nxt > `MSG_MAX |=> !out_data.commit && !servo_rst;
  endproperty
  a_len: assert property (p_len) else $error("over-long message accepted");

  property p_baud;
    @(posedge hclk) disable iff (!hresetn)
    baud_sel <= `BAUD_SEL_MAX;
  endproperty
  a_baud: assert property (p_baud) else $error("bit rate select out of range");
endmodule

// file: sim/fieldbus_master_model.sv
`timescale 1ns/1ps
module fieldbus_master_model (
  input  wire logic    hclk,
  output seq_pkg::rx_t rx,
  output logic         comm_active
);
  import seq_pkg::*;

  // Quiet link after power-up
  initial
  begin
    rx = '0;
    comm_active = 1'b0;
  end

  // Traffic seen on the segment, level
  task automatic link(input logic up);
    @(posedge hclk);
    comm_active <= up;
  endtask

  // One whole message, byte per cycle; header bytes lead, length as the caller asks
  task automatic send_msg(input msg_kind_t kind, input int len, input logic [7:0] first_byte);
    for (int i = 0; i < len; i++)
    begin
      @(posedge hclk);
      rx <= '{valid: 1'b1, first: (i == 0), last: (i == len - 1), kind: kind,
              data: (i == 0) ? first_byte : 8'(8'h10 + i)};
    end
    // Released line shows the inverse of the last byte
    @(posedge hclk);
    rx <= '{valid: 1'b0, first: 1'b0, last: 1'b0, kind: MK_OTHER, data: ~rx.data};
  endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/1ps
`include "seq_consts.svh"
module testbench;
  import seq_pkg::*;
  localparam int BLINK = 4;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, comm_active;
  logic        sys_fault, warn_alarm, servo_rst, dx_active, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  addr_sw_hi, addr_sw_lo, baud_sel;
  logic [6:0]  station_addr;
  rx_t         rx;
  out_t        out_data;
  lamp_t       bus_fault_lamp, system_fault_lamp;
  int          errors, n_compared, cyc, n_srst, n_commit, n_discard, n_outb, base;

  fieldbus_master_model master (.hclk(hclk), .rx(rx), .comm_active(comm_active));

  fieldbus_slave_startup_sequencer #(.BLINK_CYC(BLINK)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .addr_sw_hi(addr_sw_hi), .addr_sw_lo(addr_sw_lo), .comm_active(comm_active),
    .rx(rx), .sys_fault(sys_fault), .warn_alarm(warn_alarm), .out_data(out_data),
    .station_addr(station_addr), .baud_sel(baud_sel), .servo_rst(servo_rst), .dx_active(dx_active),
    .irq(irq), .bus_fault_lamp(bus_fault_lamp), .system_fault_lamp(system_fault_lamp));

  assign hready = hreadyout;

  // Clock and hang guard
  always #10 hclk = ~hclk;
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      complete_run();
    end
  end

  // Pulse and byte counters on the user side
  always @(posedge hclk)
  begin
    if (servo_rst === 1'b1) n_srst++;
    if (out_data.commit === 1'b1) n_commit++;
    if (out_data.discard === 1'b1) n_discard++;
    if (out_data.valid === 1'b1) n_outb++;
  end

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Single AHB-Lite transfer: address phase, then data phase
  task automatic ahb_xfer(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb_xfer(a, 1'b1, d, q);
    @(posedge hclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] q;
    ahb_xfer(a, 1'b0, 32'h0, q);
    check(q & mask, exp, $sformatf("read %h", a));
    check(32'(hresp), 32'h0, "response");
  endtask

  // Lamp must toggle red with green dark
  task automatic blink_check(input bit sys);
    lamp_t l;
    int    on, off, grn;
    on = 0;
    off = 0;
    grn = 0;
    repeat (4 * BLINK + 4)
    begin
      @(posedge hclk);
      l = sys ? system_fault_lamp : bus_fault_lamp;
      if (l.red === 1'b1) on++;
      if (l.red === 1'b0) off++;
      if (l.green !== 1'b0) grn++;
    end
    check(32'({on > 0, off > 0, grn == 0}), 32'h7, "blink");
  endtask

  initial
  begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'b010; hwdata = 0;
    addr_sw_hi = 4'h7; addr_sw_lo = 4'hd; sys_fault = 0; warn_alarm = 0;
    wait_cyc(10);
    hresetn <= 1'b1;
    wait_cyc(8);
    // Switches moved after capture
    addr_sw_hi <= 4'h3;
    addr_sw_lo <= 4'h4;
    wait_cyc(4);
    check(station_addr, 32'd125, "station");
    rd_chk(`R_STAT, 32'hffffffff, 32'h7d08);
    check(bus_fault_lamp, 2'b10, "bus lamp silent");
    check(system_fault_lamp, 2'b00, "sys lamp ok");
    rd_chk(8'h40, 32'hffffffff, 32'h0);
    ahb_write(`R_IRQ_EN, 32'h1f);
    rd_chk(`R_IRQ_EN, 32'hffffffff, 32'h1f);
    // Configuration and output before parameterization
    master.send_msg(MK_CFG, 2, 8'h04);
    master.send_msg(MK_OUT, 4, 8'h00);
    wait_cyc(3);
    check(n_discard, 1, "early output");
    rd_chk(`R_IRQ_ST, 32'h0b, 32'h08);
    check(irq, 1, "irq on");
    ahb_write(`R_IRQ_CLR, 32'h1f);
    master.link(1'b1);
    wait_cyc(3);
    rd_chk(`R_STAT, 32'hffffffff, 32'h7d09);
    blink_check(0);
    // Short and overlong parameterization
    for (int k = 0; k < 2; k++)
    begin
      master.send_msg(MK_PRM, k == 0 ? 6 : 245, 8'h10);
      wait_cyc(3);
      rd_chk(`R_IRQ_ST, 32'h09, 32'h08);
      ahb_write(`R_IRQ_CLR, 32'h1f);
    end
    check(n_srst, 0, "no servo reset");
    master.send_msg(MK_PRM, 10, 8'h10);
    wait_cyc(3);
    check(n_srst, 1, "servo reset");
    rd_chk(`R_HDR_LO, 32'hffffffff, 32'h13121110);
    rd_chk(`R_HDR_HI, 32'hffffffff, 32'h00161514);
    rd_chk(`R_USER, 32'hffffffff, 32'd3);
    rd_chk(`R_STAT, 32'h7, 32'h3);
    master.send_msg(MK_PRM, 10, 8'h10);
    wait_cyc(3);
    check(n_srst, 1, "second prm");
    master.send_msg(MK_CFG, 2, 8'h04);
    wait_cyc(3);
    rd_chk(`R_STAT, 32'hffffffff, 32'h7dbc);
    check(dx_active, 1, "exchange");
    check(bus_fault_lamp, 2'b01, "bus lamp green");
    // Output messages of the configured and a wrong length
    base = n_outb;
    master.send_msg(MK_OUT, 4, 8'h00);
    wait_cyc(3);
    check(n_outb - base, 4, "out bytes");
    check(n_commit, 1, "commit");
    master.send_msg(MK_OUT, 5, 8'h00);
    wait_cyc(3);
    check(n_discard, 2, "bad length");
    master.send_msg(MK_OUT, 257, 8'h00);
    wait_cyc(3);
    check(n_discard, 3, "too long");
    check(n_commit, 1, "too long kept");
    // Interrupt clear and mask
    rd_chk(`R_IRQ_ST, 32'h1f, 32'h0f);
    ahb_write(`R_IRQ_CLR, 32'h1f);
    rd_chk(`R_IRQ_ST, 32'hffffffff, 32'h0);
    check(irq, 0, "irq clear");
    ahb_write(`R_IRQ_EN, 32'h0);
    master.send_msg(MK_OUT, 4, 8'h00);
    wait_cyc(3);
    rd_chk(`R_IRQ_ST, 32'h1f, 32'h04);
    check(irq, 0, "irq masked");
    // Bit rate index bounds
    ahb_write(`R_CTRL, 32'h90);
    check(baud_sel, 9, "baud 9");
    ahb_write(`R_CTRL, 32'ha0);
    check(baud_sel, 9, "baud 10");
    sys_fault <= 1'b1;
    wait_cyc(3);
    check(system_fault_lamp, 2'b10, "sys red");
    sys_fault <= 1'b0;
    warn_alarm <= 1'b1;
    blink_check(1);
    warn_alarm <= 1'b0;
    // Restart keeps address, drops exchange
    ahb_write(`R_CTRL, 32'h91);
    wait_cyc(3);
    rd_chk(`R_STAT, 32'hffffffff, 32'h7d09);
    check(dx_active, 0, "restart");
    // Address 126 rejected at power-up
    hresetn <= 1'b0;
    addr_sw_hi <= 4'h7;
    addr_sw_lo <= 4'he;
    wait_cyc(10);
    hresetn <= 1'b1;
    wait_cyc(10);
    rd_chk(`R_STAT, 32'h0f, 32'h0);
    rd_chk(`R_IRQ_ST, 32'h1f, 32'h10);
    complete_run();
  end
endmodule
